// File: design/orx_exec.sv
// Purpose: decode and execute literal OR, file OR, file move and two-word pointer load
// Assumes: instr is steady during each four-phase cycle; file data answers in the read phase
// Notes: file memory sits outside; this block issues read and write strobes
//
// Contract
// - opcode 09: OR literal into work register
// - OR and move set sign, zero; pointer load none
// - file OR, destination bit picks work or file
// - file move, destination bit picks work or file
// - access bit 0 common bank, 1 bank register
// - eight-bit offset within chosen 256-byte bank
// - pointer load: 12-bit literal into pointer 0..2
// - pointer load decoded as two words
`timescale 1ns/10ps
`include "orx_params.svh"
module orx_exec (
   input wire logic core_clk,
   input wire logic resetn,
   input wire orx_pkg::orx_word_t instr,
   input wire logic [3:0] bank_select_register,
   input wire orx_pkg::orx_byte_t file_rdata,
   output logic [11:0] file_addr,
   output logic file_rd,
   output logic file_wr,
   output orx_pkg::orx_byte_t file_wdata,
   output orx_pkg::orx_byte_t work_reg,
   output logic sign_flag,
   output logic zero_flag,
   output orx_pkg::orx_ptr_t pointer_0,
   output orx_pkg::orx_ptr_t pointer_1,
   output orx_pkg::orx_ptr_t pointer_2,
   output logic illegal_op
);
   import orx_pkg::*;

   // ====================================================================
   // phase sequencing
   orx_phase_e phase;
   orx_phase_gen i_orx_phase_gen (
      .core_clk(core_clk),
      .resetn(resetn),
      .phase(phase)
   );
   wire ph_dec = (phase == ORX_PH_DECODE);
   wire ph_read = (phase == ORX_PH_READ);
   wire ph_proc = (phase == ORX_PH_PROC);
   wire ph_write = (phase == ORX_PH_WRITE);

   // ====================================================================
   // decode
   function automatic logic [11:0] bank_addr(input logic acc, input logic [3:0] bank,
                                             input logic [7:0] off);
      bank_addr = {(acc ? bank : `ORX_ACCESS_BANK), off};
   endfunction : bank_addr

   // sign and zero flags of an eight-bit result
   function automatic logic [1:0] nz_flags(input logic [7:0] v);
      nz_flags = {v[7], (v == 8'h00)};
   endfunction : nz_flags

   // operation held from decode to write; the codes are arbitrary
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_LIT_OR = 3'h1;
   localparam logic [2:0] OP_FILE_OR = 3'h2;
   localparam logic [2:0] OP_FILE_MOVE = 3'h3;
   localparam logic [2:0] OP_PTR_HIGH = 3'h4;
   localparam logic [2:0] OP_PTR_LOW = 3'h5;

   // set between the two words of a pointer load
   logic second_r;
   logic second_nxt;
   logic [1:0] sel_r;
   orx_byte_t w_r;
   orx_byte_t res_r;
   logic sgn_r;
   logic zro_r;
   orx_ptr_t ptr_r [0:`ORX_NUM_PTR-1];
   logic [11:0] addr_r;
   logic rd_r;
   logic wr_r;
   orx_byte_t wdata_r;
   logic ill_r;
   logic [2:0] op_r;

   wire is_iorl = (instr[15:8] == `ORX_OP_IORL);
   wire is_iorf = (instr[15:10] == `ORX_OP6_IORF);
   wire is_move = (instr[15:10] == `ORX_OP6_MOVE);
   wire is_lp1 = (instr[15:8] == `ORX_OP_LPTR1) && (instr[7:6] == `ORX_LPTR1_ZERO)
                 && (instr[5:4] != 2'h3);
   wire is_lp2 = (instr[15:8] == `ORX_OP_LPTR2);
   wire dest_file = instr[9];
   wire acc_bit = instr[8];
   wire [1:0] ptr_sel = instr[5:4];
   wire [3:0] lit_hi = instr[3:0];
   wire [7:0] lit_lo = instr[7:0];
   wire [11:0] f_addr = bank_addr(acc_bit, bank_select_register, lit_lo);
   wire [2:0] op_first = is_iorl ? OP_LIT_OR :
                         is_iorf ? OP_FILE_OR :
                         is_move ? OP_FILE_MOVE :
                         is_lp1 ? OP_PTR_HIGH : OP_NONE;
   wire [2:0] op_second = is_lp2 ? OP_PTR_LOW : OP_NONE;
   wire [2:0] op_dec = second_r ? op_second : op_first;
   wire bad_dec = (op_dec == OP_NONE);
   wire dec_file = (op_dec == OP_FILE_OR) || (op_dec == OP_FILE_MOVE);
   wire op_lit = (op_r == OP_LIT_OR);
   wire op_move = (op_r == OP_FILE_MOVE);
   wire op_phi = (op_r == OP_PTR_HIGH);
   wire op_plo = (op_r == OP_PTR_LOW);
   wire file_op = (op_r == OP_FILE_OR) || op_move;
   wire [7:0] operand = file_op ? file_rdata : lit_lo;
   wire [7:0] result = op_move ? operand : (w_r | operand);
   wire flags_upd = op_lit || file_op;
   wire wr_work = op_lit || (file_op && !dest_file);
   wire wr_file = file_op && dest_file;
   wire [1:0] res_nz = nz_flags(res_r);
   wire ptr_hi_wr = ph_write && op_phi;
   wire ptr_lo_wr = ph_write && op_plo;

   assign second_nxt = ph_write ? op_phi : second_r;

   // ====================================================================
   // sequencing of one instruction cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         op_r <= 3'h0;
         ill_r <= 1'b0;
         addr_r <= 12'h000;
         rd_r <= 1'b0;
      end else if (ph_dec) begin
         op_r <= op_dec;
         ill_r <= bad_dec;
         addr_r <= f_addr;
         rd_r <= dec_file;
      end else if (ph_read) begin
         rd_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         res_r <= 8'h00;
      end else if (ph_read) begin
         res_r <= result;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_r <= 1'b0;
         wdata_r <= 8'h00;
      end else if (ph_proc) begin
         wr_r <= wr_file;
         wdata_r <= res_r;
      end else begin
         wr_r <= 1'b0;
      end
   end

   // ====================================================================
   // working register and flags
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         w_r <= `ORX_W_RESET;
         sgn_r <= 1'b0;
         zro_r <= 1'b0;
      end else if (ph_write) begin
         if (wr_work) begin
            w_r <= res_r;
         end
         if (flags_upd) begin
            sgn_r <= res_nz[1];
            zro_r <= res_nz[0];
         end
      end
   end

   // ====================================================================
   // pointer load sequencing
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         second_r <= 1'b0;
         sel_r <= 2'h0;
      end else begin
         second_r <= second_nxt;
         if (ptr_hi_wr) begin
            sel_r <= ptr_sel;
         end
      end
   end

   // ====================================================================
   // pointer registers: high four bits in the first cycle, low byte in the second
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < `ORX_NUM_PTR; i++) begin
            ptr_r[i] <= `ORX_PTR_RESET;
         end
      end else if (ph_write) begin
         for (int i = 0; i < `ORX_NUM_PTR; i++) begin
            if (ptr_hi_wr && ptr_sel == 2'(i)) begin
               ptr_r[i][11:8] <= lit_hi;
            end
            if (ptr_lo_wr && sel_r == 2'(i)) begin
               ptr_r[i][7:0] <= lit_lo;
            end
         end
      end
   end

   // ====================================================================
   // outputs, each straight from a flip-flop
   assign file_addr = addr_r;
   assign file_rd = rd_r;
   assign file_wr = wr_r;
   assign file_wdata = wdata_r;
   assign work_reg = w_r;
   assign sign_flag = sgn_r;
   assign zero_flag = zro_r;
   assign pointer_0 = ptr_r[0];
   assign pointer_1 = ptr_r[1];
   assign pointer_2 = ptr_r[2];
   assign illegal_op = ill_r;
endmodule : orx_exec

// File: design/orx_params.svh
// Purpose: constants for the or/move/pointer-load execute block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: definitions only
`ifndef ORX_PARAMS_SVH
`define ORX_PARAMS_SVH
`define ORX_OP_IORL 8'h09
`define ORX_OP6_IORF 6'h04
`define ORX_OP6_MOVE 6'h14
`define ORX_OP_LPTR1 8'hee
`define ORX_OP_LPTR2 8'hf0
`define ORX_LPTR1_ZERO 2'h0
`define ORX_ACCESS_BANK 4'h0
`define ORX_NUM_PTR 3
`define ORX_W_RESET 8'h00
`define ORX_BANK_RESET 4'h0
`define ORX_PTR_RESET 12'h000
`endif

// File: design/orx_pkg.sv
// Purpose: types for the or/move/pointer-load execute block
// Assumes: one instruction cycle = four phases
// Notes: none
package orx_pkg;
   typedef enum logic [3:0] {
      ORX_PH_DECODE = 4'b0001,
      ORX_PH_READ = 4'b0010,
      ORX_PH_PROC = 4'b0100,
      ORX_PH_WRITE = 4'b1000
   } orx_phase_e;
   typedef logic [7:0] orx_byte_t;
   typedef logic [15:0] orx_word_t;
   typedef logic [11:0] orx_ptr_t;
endpackage : orx_pkg

// File: design/orx_phase_gen.sv
// Purpose: four-phase sequencer of the instruction cycle
// Assumes: one clock, phase advances every clock
// Notes: phase is one-hot, decode phase after reset
`timescale 1ns/10ps
module orx_phase_gen (
   input wire logic core_clk,
   input wire logic resetn,
   output orx_pkg::orx_phase_e phase
);
   import orx_pkg::*;
   orx_phase_e phase_r;
   orx_phase_e phase_nxt;
   always_comb begin
      case (phase_r)
         ORX_PH_DECODE: phase_nxt = ORX_PH_READ;
         ORX_PH_READ: phase_nxt = ORX_PH_PROC;
         ORX_PH_PROC: phase_nxt = ORX_PH_WRITE;
         ORX_PH_WRITE: phase_nxt = ORX_PH_DECODE;
         default: phase_nxt = ORX_PH_DECODE;
      endcase
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= ORX_PH_DECODE;
      end else begin
         phase_r <= phase_nxt;
      end
   end
   assign phase = phase_r;
endmodule : orx_phase_gen

// File: tb/orx_exec_monitor.sv
// Purpose: port checks for orx_exec
// Assumes: phases restart at reset release
// Notes: bound after the module
`timescale 1ns/10ps
module orx_exec_monitor (
   input wire logic core_clk,
   input wire logic resetn,
   input wire orx_pkg::orx_word_t instr,
   input wire logic [3:0] bank_select_register,
   input wire orx_pkg::orx_byte_t file_rdata,
   input wire logic [11:0] file_addr,
   input wire logic file_rd,
   input wire logic file_wr,
   input wire orx_pkg::orx_byte_t work_reg,
   input wire logic sign_flag,
   input wire logic zero_flag,
   input wire orx_pkg::orx_ptr_t pointer_0
);
   import orx_pkg::*;
   logic [1:0] ph_r;
   wire wr_end = ph_r == 2'h3;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         ph_r <= 2'h0;
      else
         ph_r <= ph_r + 2'h1;
   end
   // ====================
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_rd_one; file_rd |=> !file_rd; endproperty
   a_rd_one: assert property (p_rd_one) else $error("read strobe too long");
   property p_dest; file_rd |-> ##2 (file_wr == instr[9]); endproperty
   a_dest: assert property (p_dest) else $error("write strobe wrong");
   property p_bank;
      file_rd |-> file_addr == {(instr[8] ? bank_select_register : 4'h0), instr[7:0]};
   endproperty
   a_bank: assert property (p_bank) else $error("file address wrong");
   property p_lit;
      wr_end && instr[15:8] == 8'h09 |=> work_reg == ($past(work_reg) | $past(instr[7:0]));
   endproperty
   a_lit: assert property (p_lit) else $error("literal or wrong");
   property p_nz;
      wr_end && instr[15:8] == 8'h09 |=>
         sign_flag == work_reg[7] && zero_flag == (work_reg == 8'h00);
   endproperty
   a_nz: assert property (p_nz) else $error("flags wrong");
   property p_keep;
      wr_end && instr[15:8] == 8'hee |=>
         $stable(work_reg) && $stable(sign_flag) && $stable(zero_flag);
   endproperty
   a_keep: assert property (p_keep) else $error("pointer load changed state");
   property p_hi;
      wr_end && instr[15:8] == 8'hee && instr[5:4] == 2'h0 |=>
         pointer_0[11:8] == $past(instr[3:0]);
   endproperty
   a_hi: assert property (p_hi) else $error("pointer high wrong");
   property p_mov; wr_end && instr[15:9] == 7'h28 |=> work_reg == $past(file_rdata, 3); endproperty
   a_mov: assert property (p_mov) else $error("move wrong");
   c_fwr: cover property (file_wr);
   c_ptr: cover property (wr_end && instr[15:8] == 8'hf0);
   c_mov: cover property (wr_end && instr[15:9] == 7'h28);
endmodule : orx_exec_monitor
bind orx_exec orx_exec_monitor i_orx_exec_monitor (.core_clk(core_clk), .resetn(resetn),
   .instr(instr), .bank_select_register(bank_select_register), .file_rdata(file_rdata),
   .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .work_reg(work_reg),
   .sign_flag(sign_flag), .zero_flag(zero_flag), .pointer_0(pointer_0));

// File: tb/orx_exec_bench.sv
// Purpose: bench for orx_exec
// Assumes: instr held per 4-clock cycle
// Notes: none
`timescale 1ns/10ps
module orx_exec_bench;
   import orx_pkg::*;
   logic core_clk, resetn, fr, fw, sf, zf, ill, swr, srd;
   orx_word_t instr;
   logic [3:0] bank;
   orx_byte_t rd, wd, w, sw;
   logic [11:0] fa, sa;
   orx_ptr_t p0, p1, p2;
   int bad_count = 0;
   int n_tests = 0;
   orx_exec i_orx_exec (.core_clk(core_clk), .resetn(resetn), .instr(instr),
      .bank_select_register(bank), .file_rdata(rd), .file_addr(fa), .file_rd(fr),
      .file_wr(fw), .file_wdata(wd), .work_reg(w), .sign_flag(sf), .zero_flag(zf),
      .pointer_0(p0), .pointer_1(p1), .pointer_2(p2), .illegal_op(ill));
   // ====================
   // helpers
   task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one full instruction cycle, catching the read and write strobes
   task ex(input orx_word_t iw, input orx_byte_t d);
      instr = iw;
      rd = d;
      swr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(negedge core_clk);
         if (i == 0) begin
            sa = fa;
            srd = fr;
         end
         if (fw === 1'b1) begin
            swr = 1'b1;
            sw = wd;
         end
      end
   endtask : ex
   task wnz(input orx_byte_t e, input logic n, input logic z);
      chk("work", {4'h0, e}, {4'h0, w});
      chk("flags", {10'h0, n, z}, {10'h0, sf, zf});
      chk("illegal", 12'h000, {11'h0, ill});
   endtask : wnz
   function orx_ptr_t ptr(input int s);
      return s == 0 ? p0 : (s == 1 ? p1 : p2);
   endfunction : ptr
   // ====================
   // scenarios
   task t_lit;
      ex(16'h0900, 8'h00);
      wnz(8'h00, 1'b0, 1'b1);
      chk("rd", 12'h000, {11'h0, srd});
      ex(16'h099a, 8'h00);
      wnz(8'h9a, 1'b1, 1'b0);
      ex(16'h0935, 8'h00);
      wnz(8'hbf, 1'b1, 1'b0);
   endtask : t_lit
   task t_file;
      bank = 4'h5;
      ex(16'h1233, 8'h40);
      chk("rd", 12'h001, {11'h0, srd});
      chk("addr", 12'h033, sa);
      chk("wdata", 12'h1ff, {3'h0, swr, sw});
      wnz(8'hbf, 1'b1, 1'b0);
      ex(16'h1122, 8'h40);
      chk("addr", 12'h522, sa);
      chk("wr", 12'h000, {11'h0, swr});
      wnz(8'hff, 1'b1, 1'b0);
   endtask : t_file
   task t_move;
      ex(16'h5344, 8'h80);
      chk("wdata", 12'h180, {3'h0, swr, sw});
      wnz(8'hff, 1'b1, 1'b0);
      ex(16'h5055, 8'h00);
      chk("addr", 12'h055, sa);
      wnz(8'h00, 1'b0, 1'b1);
   endtask : t_move
   task t_ptr;
      logic [11:0] k;
      for (int s = 0; s < 3; s++) begin
         k = 12'h3ab + 12'(s * 273);
         ex({8'hee, 2'h0, 2'(s), k[11:8]}, 8'h00);
         chk("ptr_hi", {k[11:8], 8'h00}, ptr(s));
         ex({8'hf0, k[7:0]}, 8'h00);
         chk("ptr", k, ptr(s));
         wnz(8'h00, 1'b0, 1'b1);
      end
   endtask : t_ptr
   task t_bad;
      ex(16'hee05, 8'h00);
      ex(16'hffff, 8'h00);
      chk("ptr_keep", 12'h5ab, p0);
      chk("illegal", 12'h001, {11'h0, ill});
      ex(16'hee3f, 8'h00);
      chk("illegal_sel", 12'h001, {11'h0, ill});
      chk("ptr1_keep", 12'h4bc, p1);
      chk("ptr2_keep", 12'h5cd, p2);
      chk("flags_keep", 12'h001, {10'h0, sf, zf});
      ex(16'hf0aa, 8'h00);
      chk("illegal_lone", 12'h001, {11'h0, ill});
      chk("ptr0_keep", 12'h5ab, p0);
   endtask : t_bad
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      resetn = 1'b0;
      instr = 16'h0000;
      bank = 4'h0;
      rd = 8'h00;
      repeat (20) @(negedge core_clk);
      resetn = 1'b1;
      t_lit();
      t_file();
      t_move();
      t_ptr();
      t_bad();
      finish_test();
   end
endmodule : orx_exec_bench
